// ---- core/fss_pkg.sv ----
package fss_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ        = 50;
	// Self-timed erase and program durations in microseconds.
	localparam int unsigned SE_TIME_US     = 100000;
	localparam int unsigned PP_TIME_US     = 1000;
	localparam int unsigned SE_CYCLES      = SE_TIME_US * CLK_MHZ;
	localparam int unsigned PP_CYCLES      = PP_TIME_US * CLK_MHZ;

	// ****************************************************************
	// Instruction opcodes
	// ****************************************************************
	localparam logic [7:0]  OP_WR_ENABLE   = 8'h06;
	localparam logic [7:0]  OP_WR_DISABLE  = 8'h04;
	localparam logic [7:0]  OP_RD_STATUS1  = 8'h05;
	localparam logic [7:0]  OP_RD_STATUS2  = 8'h35;
	localparam logic [7:0]  OP_SEC_ERASE   = 8'h44;
	localparam logic [7:0]  OP_SEC_PROGRAM = 8'h42;

	// ****************************************************************
	// Frame layout
	// ****************************************************************
	localparam logic [2:0]  LAST_BIT       = 3'h7;
	localparam logic [2:0]  FIRST_BIT      = 3'h0;
	localparam logic [2:0]  OPCODE_BYTES   = 3'h1;
	localparam logic [2:0]  HEADER_BYTES   = 3'h4;
	localparam logic [2:0]  FIRST_DATA     = 3'h5;
	localparam logic [2:0]  BYTE_CNT_MAX   = 3'h7;
	localparam logic [2:0]  ADDR_LAST_BYTE = 3'h3;

	// ****************************************************************
	// Security area geometry
	// ****************************************************************
	localparam int unsigned PAGE_BYTES     = 256;
	localparam int unsigned PAGES          = 4;
	localparam int unsigned AREA_BYTES     = PAGE_BYTES * PAGES;
	localparam logic [9:0]  AREA_LAST      = 10'h3ff;
	localparam logic [9:0]  PAGE_LAST      = 10'h0ff;
	localparam logic [7:0]  ERASED_BYTE    = 8'hff;

	// ****************************************************************
	// Status bits, pin sampling and buffering
	// ****************************************************************
	localparam int unsigned SR1_BUSY_BIT   = 0;
	localparam int unsigned SR1_LATCH_BIT  = 1;
	localparam int unsigned SR2_LOCK_BIT   = 2;
	localparam int unsigned PIN_SCLK       = 0;
	localparam int unsigned PIN_CS         = 1;
	localparam int unsigned PIN_SDI        = 2;
	localparam int unsigned PIN_LOCK       = 3;
	localparam int unsigned PIN_QUAD       = 4;
	localparam int unsigned PIN_COUNT      = 5;
	localparam logic [4:0]  PIN_RST_VAL    = 5'h02;
	localparam int unsigned FIFO_WIDTH     = 16;
	localparam int unsigned FIFO_DEPTH     = 32;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ERASE,
		ST_PROGRAM
	} fss_state_e;

endpackage

// ---- core/fss_stream_if.sv ----
`timescale 1ns/1ps
interface fss_stream_if #(
	parameter int unsigned WIDTH = fss_pkg::FIFO_WIDTH
);
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [WIDTH-1:0] pop_data;

	modport fifo (
		input  push_valid,
		input  push_data,
		input  pop_ready,
		output push_ready,
		output pop_valid,
		output pop_data
	);
	modport user (
		output push_valid,
		output push_data,
		output pop_ready,
		input  push_ready,
		input  pop_valid,
		input  pop_data
	);
endinterface

// ---- core/fss_fifo.sv ----
`timescale 1ns/1ps
module fss_fifo #(
	parameter int unsigned WIDTH = fss_pkg::FIFO_WIDTH,
	parameter int unsigned DEPTH = fss_pkg::FIFO_DEPTH
)(
	input wire logic core_clk,
	input wire logic rst,
	fss_stream_if.fifo s
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ff;
	logic [AW:0]      rd_ff;
	logic             full;
	logic             empty;

	// One extra pointer bit tells a full ring from an empty one.
	assign empty = (wr_ff == rd_ff);
	assign full  = (wr_ff[AW] != rd_ff[AW]) &&
		(wr_ff[AW-1:0] == rd_ff[AW-1:0]);

	assign s.push_ready = !full;
	assign s.pop_valid  = !empty;
	assign s.pop_data   = mem[rd_ff[AW-1:0]];

	always_ff @(posedge core_clk) begin
		if (s.push_valid && !full) begin
			mem[wr_ff[AW-1:0]] <= s.push_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ff <= '0;
		end else if (s.push_valid && !full) begin
			wr_ff <= wr_ff + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_ff <= '0;
		end else if (s.pop_ready && !empty) begin
			rd_ff <= rd_ff + 1'b1;
		end
	end
endmodule

// ---- core/fss_security_area.sv ----
// Function
// - Four 256-byte pages, apart from main array.
// - Erase needs write-enable latch set beforehand.
// - Chip select must rise on byte boundary.
// - Valid erase starts self-timed sector erase.
// - Status read still answered during erase.
// - Write-in-progress high whole cycle, then cleared.
// - Erase completion clears write-enable latch.
// - Lock bit set ignores every erase.
// - Program writes 1 to 256 bytes.
// - Program needs write-enable latch set beforehand.
// - Lock bit set ignores every program.
// - Erase and program only in serial mode.
`timescale 1ns/1ps
module fss_security_area #(
	parameter int unsigned ERASE_CYCLES   = fss_pkg::SE_CYCLES,
	parameter int unsigned PROGRAM_CYCLES = fss_pkg::PP_CYCLES,
	parameter int unsigned FIFO_DEPTH     = fss_pkg::FIFO_DEPTH
)(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       serial_data_in,
	input  wire logic       security_area_lock_bit,
	input  wire logic       quad_mode,
	input  wire logic [9:0] rd_addr,
	output logic            serial_data_out,
	output logic            serial_data_oe,
	output logic            write_in_progress,
	output logic            write_enable_latch,
	output logic [7:0]      rd_data
);

	// ****************************************************************
	// Pin synchronisers and edge detection
	// ****************************************************************
	logic [fss_pkg::PIN_COUNT-1:0] pin_meta_ff;
	logic [fss_pkg::PIN_COUNT-1:0] pin_ff;
	logic                          sclk_last_ff;
	logic                          cs_last_ff;
	logic                          sclk_rise;
	logic                          sclk_fall;
	logic                          cs_fall;
	logic                          cs_rise;
	logic                          selected;
	logic                          sdi;
	logic                          locked;
	logic                          quad;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_meta_ff <= fss_pkg::PIN_RST_VAL;
			pin_ff      <= fss_pkg::PIN_RST_VAL;
		end else begin
			pin_meta_ff <= {quad_mode, security_area_lock_bit,
				serial_data_in, cs_n, sclk};
			pin_ff      <= pin_meta_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sclk_last_ff <= 1'b0;
			cs_last_ff   <= 1'b1;
		end else begin
			sclk_last_ff <= pin_ff[fss_pkg::PIN_SCLK];
			cs_last_ff   <= pin_ff[fss_pkg::PIN_CS];
		end
	end

	assign selected  = !pin_ff[fss_pkg::PIN_CS];
	assign sclk_rise = pin_ff[fss_pkg::PIN_SCLK] && !sclk_last_ff && selected;
	assign sclk_fall = !pin_ff[fss_pkg::PIN_SCLK] && sclk_last_ff && selected;
	assign cs_fall   = selected && cs_last_ff;
	assign cs_rise   = !selected && !cs_last_ff;
	assign sdi       = pin_ff[fss_pkg::PIN_SDI];
	assign locked    = pin_ff[fss_pkg::PIN_LOCK];
	assign quad      = pin_ff[fss_pkg::PIN_QUAD];

	// ****************************************************************
	// Instruction shifter
	// ****************************************************************
	logic [7:0]  shift_ff;
	logic [2:0]  bit_ff;
	logic [2:0]  byte_cnt_ff;
	logic [7:0]  opcode_ff;
	logic [23:0] addr_ff;
	logic [7:0]  data_idx_ff;
	logic [7:0]  nxt_shift;
	logic        byte_done;
	logic [7:0]  cur_opcode;

	assign nxt_shift  = {shift_ff[6:0], sdi};
	assign byte_done  = sclk_rise && (bit_ff == fss_pkg::LAST_BIT);
	assign cur_opcode = (byte_cnt_ff == 3'h0) ? nxt_shift : opcode_ff;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			shift_ff    <= '0;
			bit_ff      <= fss_pkg::FIRST_BIT;
			byte_cnt_ff <= '0;
			opcode_ff   <= '0;
			addr_ff     <= '0;
			data_idx_ff <= '0;
		end else if (cs_fall) begin
			bit_ff      <= fss_pkg::FIRST_BIT;
			byte_cnt_ff <= '0;
			data_idx_ff <= '0;
		end else if (sclk_rise) begin
			shift_ff <= nxt_shift;
			bit_ff   <= bit_ff + 3'h1;
			if (bit_ff == fss_pkg::LAST_BIT) begin
				if (byte_cnt_ff != fss_pkg::BYTE_CNT_MAX) begin
					byte_cnt_ff <= byte_cnt_ff + 3'h1;
				end
				if (byte_cnt_ff == 3'h0) begin
					opcode_ff <= nxt_shift;
				end else if (byte_cnt_ff <= fss_pkg::ADDR_LAST_BYTE) begin
					addr_ff <= {addr_ff[15:0], nxt_shift};
				end else begin
					// Column wraps inside the page, as a page write does.
					data_idx_ff <= data_idx_ff + 8'h01;
				end
			end
		end
	end

	// ****************************************************************
	// Command qualification
	// ****************************************************************
	fss_pkg::fss_state_e state_ff;
	logic        busy_ff;
	logic        pend_ff;
	logic        wr_en_ff;
	logic        whole_bytes;
	logic        write_ok;
	logic        erase_go;
	logic        prog_go;
	logic        prog_frame_ok;
	logic        wren_go;
	logic        wrdi_go;
	logic        finish;

	assign whole_bytes = (bit_ff == fss_pkg::FIRST_BIT);
	// Latch, lock, serial mode and idle engine all gate a write.
	assign write_ok = wr_en_ff && !locked && !quad && !busy_ff &&
		!pend_ff;

	assign erase_go = cs_rise && whole_bytes && write_ok &&
		(opcode_ff == fss_pkg::OP_SEC_ERASE) &&
		(byte_cnt_ff == fss_pkg::HEADER_BYTES);
	assign prog_go = cs_rise && whole_bytes && write_ok &&
		(opcode_ff == fss_pkg::OP_SEC_PROGRAM) &&
		(byte_cnt_ff >= fss_pkg::FIRST_DATA);
	assign prog_frame_ok = write_ok &&
		(cur_opcode == fss_pkg::OP_SEC_PROGRAM);
	assign wren_go = cs_rise && whole_bytes && !busy_ff && !pend_ff &&
		(opcode_ff == fss_pkg::OP_WR_ENABLE) &&
		(byte_cnt_ff == fss_pkg::OPCODE_BYTES);
	assign wrdi_go = cs_rise && whole_bytes && !busy_ff && !pend_ff &&
		(opcode_ff == fss_pkg::OP_WR_DISABLE) &&
		(byte_cnt_ff == fss_pkg::OPCODE_BYTES);

	// ****************************************************************
	// Data byte buffer
	// ****************************************************************
	fss_stream_if #(.WIDTH(fss_pkg::FIFO_WIDTH)) data_q ();

	// Each entry carries the target column with its data byte.
	assign data_q.push_valid = byte_done && prog_frame_ok &&
		(byte_cnt_ff >= fss_pkg::HEADER_BYTES);
	assign data_q.push_data  = {addr_ff[7:0] + data_idx_ff, nxt_shift};
	// The page buffer may not change under a running commit.
	assign data_q.pop_ready  = (state_ff == fss_pkg::ST_IDLE);

	fss_fifo #(
		.WIDTH (fss_pkg::FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.rst      (rst),
		.s        (data_q)
	);

	logic [7:0]                      page_buf [fss_pkg::PAGE_BYTES];
	logic [fss_pkg::PAGE_BYTES-1:0]  page_mask_ff;
	logic                            pop_take;
	logic [7:0]                      pop_col;

	assign pop_take = data_q.pop_valid && data_q.pop_ready;
	assign pop_col  = data_q.pop_data[15:8];

	always_ff @(posedge core_clk) begin
		if (pop_take) begin
			page_buf[pop_col] <= data_q.pop_data[7:0];
		end
	end

	// A byte arriving with the frame start still marks its column.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			page_mask_ff <= '0;
		end else begin
			if (cs_fall && !pend_ff && !busy_ff) begin
				page_mask_ff <= '0;
			end
			if (pop_take) begin
				page_mask_ff[pop_col] <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Self-timed engine
	// ****************************************************************
	logic [7:0]  area [fss_pkg::AREA_BYTES];
	logic [9:0]  walk_ff;
	logic        walk_done_ff;
	logic [31:0] timer_ff;
	logic [1:0]  page_ff;
	logic [31:0] limit;
	logic [9:0]  walk_last;
	logic [9:0]  prog_idx;

	assign limit = (state_ff == fss_pkg::ST_ERASE) ?
		32'(ERASE_CYCLES - 1) : 32'(PROGRAM_CYCLES - 1);
	assign walk_last = (state_ff == fss_pkg::ST_ERASE) ?
		fss_pkg::AREA_LAST : fss_pkg::PAGE_LAST;
	assign finish = (state_ff != fss_pkg::ST_IDLE) && walk_done_ff &&
		(timer_ff >= limit);
	assign prog_idx = {page_ff, walk_ff[7:0]};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff     <= fss_pkg::ST_IDLE;
			busy_ff      <= 1'b0;
			pend_ff      <= 1'b0;
			walk_ff      <= '0;
			walk_done_ff <= 1'b0;
			timer_ff     <= '0;
			page_ff      <= '0;
		end else begin
			case (state_ff)
				fss_pkg::ST_IDLE: begin
					walk_ff      <= '0;
					walk_done_ff <= 1'b0;
					timer_ff     <= '0;
					if (erase_go) begin
						state_ff <= fss_pkg::ST_ERASE;
						busy_ff  <= 1'b1;
					end else if (prog_go) begin
						pend_ff <= 1'b1;
						busy_ff <= 1'b1;
						page_ff <= addr_ff[9:8];
					end else if (pend_ff && !data_q.pop_valid) begin
						// Commit only once every buffered byte is placed.
						pend_ff  <= 1'b0;
						state_ff <= fss_pkg::ST_PROGRAM;
					end
				end
				fss_pkg::ST_ERASE, fss_pkg::ST_PROGRAM: begin
					timer_ff <= timer_ff + 32'h1;
					if (walk_ff == walk_last) begin
						walk_done_ff <= 1'b1;
					end else begin
						walk_ff <= walk_ff + 10'h001;
					end
					if (finish) begin
						state_ff <= fss_pkg::ST_IDLE;
						busy_ff  <= 1'b0;
					end
				end
				default: begin
					state_ff <= fss_pkg::ST_IDLE;
					busy_ff  <= 1'b0;
				end
			endcase
		end
	end

	// Programming can only clear bits; page_mask_ff skips unwritten columns, so they stay intact.
	always_ff @(posedge core_clk) begin
		if (state_ff == fss_pkg::ST_ERASE && !walk_done_ff) begin
			area[walk_ff] <= fss_pkg::ERASED_BYTE;
		end else if (state_ff == fss_pkg::ST_PROGRAM && !walk_done_ff &&
			page_mask_ff[walk_ff[7:0]]) begin
			area[prog_idx] <= area[prog_idx] & page_buf[walk_ff[7:0]];
		end
	end

	always_ff @(posedge core_clk) begin
		rd_data <= area[rd_addr];
	end

	// ****************************************************************
	// Write-enable latch
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_en_ff <= 1'b0;
		end else if (finish) begin
			wr_en_ff <= 1'b0;
		end else if (wren_go) begin
			wr_en_ff <= 1'b1;
		end else if (wrdi_go) begin
			wr_en_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// Status readout
	// ****************************************************************
	logic [7:0] status1;
	logic [7:0] status2;
	logic [7:0] out_sr_ff;
	logic       out_en_ff;
	logic       so_ff;
	logic       is_status;

	always_comb begin
		status1 = '0;
		status2 = '0;
		status1[fss_pkg::SR1_BUSY_BIT]  = busy_ff;
		status1[fss_pkg::SR1_LATCH_BIT] = wr_en_ff;
		status2[fss_pkg::SR2_LOCK_BIT]  = locked;
	end

	assign is_status = (cur_opcode == fss_pkg::OP_RD_STATUS1) ||
		(cur_opcode == fss_pkg::OP_RD_STATUS2);

	// Reloaded each byte so a polling host sees the flag fall.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_sr_ff <= '0;
			out_en_ff <= 1'b0;
			so_ff     <= 1'b0;
		end else if (cs_rise) begin
			out_en_ff <= 1'b0;
			so_ff     <= 1'b0;
		end else if (byte_done && is_status) begin
			out_en_ff <= 1'b1;
			out_sr_ff <= (cur_opcode == fss_pkg::OP_RD_STATUS1) ?
				status1 : status2;
		end else if (sclk_fall && out_en_ff) begin
			so_ff     <= out_sr_ff[7];
			out_sr_ff <= {out_sr_ff[6:0], 1'b0};
		end
	end

	assign serial_data_out    = so_ff;
	assign serial_data_oe     = out_en_ff;
	assign write_in_progress  = busy_ff;
	assign write_enable_latch = wr_en_ff;

endmodule

// ---- tb/fss_security_area_props.sv ----
`timescale 1ns/1ps
module fss_security_area_props #(
	parameter int unsigned ERASE_CYCLES   = 2000,
	parameter int unsigned PROGRAM_CYCLES = 300
)(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       sclk,
	input wire logic       cs_n,
	input wire logic       serial_data_in,
	input wire logic       security_area_lock_bit,
	input wire logic       quad_mode,
	input wire logic [9:0] rd_addr,
	input wire logic       serial_data_out,
	input wire logic       serial_data_oe,
	input wire logic       write_in_progress,
	input wire logic       write_enable_latch,
	input wire logic [7:0] rd_data
);
	// ****
	// Busy length
	// ****
	// A counter bounds the busy period at both ends without long repeats.
	logic [31:0] busy_cnt_ff;
	always_ff @(posedge core_clk) begin
		if (rst || !write_in_progress) begin
			busy_cnt_ff <= 32'h0;
		end else begin
			busy_cnt_ff <= busy_cnt_ff + 32'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_locked; security_area_lock_bit [*8]; endsequence
	sequence s_quad; quad_mode [*8]; endsequence
	sequence s_deselected; cs_n [*6]; endsequence
	sequence s_start; $rose(write_in_progress); endsequence
	property p_start_en; s_start |-> write_enable_latch; endproperty
	property p_lock; s_locked |=> !$rose(write_in_progress); endproperty
	property p_quad; s_quad |=> !$rose(write_in_progress); endproperty
	property p_start; s_start |-> $past(cs_n, 2); endproperty
	property p_en_clr;
		$fell(write_in_progress) |-> !write_enable_latch;
	endproperty
	property p_min;
		$fell(write_in_progress) |-> busy_cnt_ff >= PROGRAM_CYCLES;
	endproperty
	property p_max;
		write_in_progress |-> busy_cnt_ff < ERASE_CYCLES + 1100;
	endproperty
	property p_en_set;
		$rose(write_enable_latch) |-> $past(cs_n, 2) && !write_in_progress;
	endproperty
	property p_oe; s_deselected |-> !serial_data_oe; endproperty
	a_start_en: assert property (p_start_en)
		else $error("busy without write enable");
	a_lock: assert property (p_lock)
		else $error("busy while locked");
	a_quad: assert property (p_quad)
		else $error("busy in quad mode");
	a_start: assert property (p_start)
		else $error("busy not after frame end");
	a_en_clr: assert property (p_en_clr)
		else $error("write enable kept after cycle");
	a_min: assert property (p_min)
		else $error("busy too short");
	a_max: assert property (p_max)
		else $error("busy too long");
	a_en_set: assert property (p_en_set)
		else $error("write enable set badly");
	a_oe: assert property (p_oe)
		else $error("output driven while deselected");
endmodule
bind fss_security_area fss_security_area_props #(
	.ERASE_CYCLES(ERASE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES)
) i_fss_security_area_props (
	.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
	.serial_data_in(serial_data_in),
	.security_area_lock_bit(security_area_lock_bit),
	.quad_mode(quad_mode), .rd_addr(rd_addr),
	.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
	.write_in_progress(write_in_progress),
	.write_enable_latch(write_enable_latch), .rd_data(rd_data)
);

// ---- tb/fss_spi_host.sv ----
`timescale 1ns/1ps
module fss_spi_host (
	input  wire logic core_clk,
	input  wire logic so,
	output logic      sclk,
	output logic      cs_n,
	output logic      si
);
	logic [7:0] tx[$];
	logic [7:0] rx[$];
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// ****
	// Frame
	// ****
	// Extra bits past the bytes make a frame that ends mid-byte.
	task automatic frame(input int extra);
		logic [7:0] b;
		logic [7:0] r;
		rx = {};
		@(negedge core_clk);
		cs_n = 1'b0;
		#80;
		for (int i = 0; i < tx.size() * 8 + extra; i++) begin
			b = (i / 8 < tx.size()) ? tx[i / 8] : 8'h00;
			si = b[7 - i % 8];
			#80 sclk = 1'b1;
			#80 r = {r[6:0], so};
			if (i % 8 == 7) begin
				rx.push_back(r);
			end
			sclk = 1'b0;
		end
		#80 cs_n = 1'b1;
		// The released data line must not keep its last bit.
		si = ~si;
		#160;
	endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("FAIL %0t: got %h expected %h", $time, got, exp); \
	end \
end
module tb;
	localparam int unsigned ERASE_CYC = 2000;
	localparam int unsigned PROG_CYC  = 300;
	logic       core_clk;
	logic       rst;
	logic       sclk;
	logic       cs_n;
	logic       sdi;
	logic       lock;
	logic       quad;
	logic [9:0] rd_addr;
	logic       sdo;
	logic       sdo_oe;
	logic       busy;
	logic       wr_en;
	logic [7:0] rd_data;
	wire        so_wire;
	int         failures;
	int         n_tests;
	logic [7:0] q[$];
	assign so_wire = sdo_oe ? sdo : 1'bz;
	always #10 core_clk = ~core_clk;
	fss_security_area #(.ERASE_CYCLES(ERASE_CYC), .PROGRAM_CYCLES(PROG_CYC))
	i_fss_security_area (
		.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.serial_data_in(sdi), .security_area_lock_bit(lock),
		.quad_mode(quad), .rd_addr(rd_addr), .serial_data_out(sdo),
		.serial_data_oe(sdo_oe), .write_in_progress(busy),
		.write_enable_latch(wr_en), .rd_data(rd_data)
	);
	fss_spi_host i_fss_spi_host (
		.core_clk(core_clk), .so(so_wire), .sclk(sclk), .cs_n(cs_n),
		.si(sdi)
	);
	// ****
	// Helpers
	// ****
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic send(input logic [7:0] b[$], input int extra);
		i_fss_spi_host.tx = b;
		i_fss_spi_host.frame(extra);
	endtask
	task automatic wren;
		send({fss_pkg::OP_WR_ENABLE}, 0);
	endtask
	task automatic erase(input int extra);
		send({fss_pkg::OP_SEC_ERASE, 8'h00, 8'h00, 8'h00}, extra);
	endtask
	task automatic status(input logic [7:0] exp);
		send({fss_pkg::OP_RD_STATUS1, 8'h00}, 0);
		`CHK(i_fss_spi_host.rx[1], exp)
	endtask
	task automatic status2(input logic [7:0] exp);
		send({fss_pkg::OP_RD_STATUS2, 8'h00}, 0);
		`CHK(i_fss_spi_host.rx[1], exp)
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		rd_addr = a;
		cyc(2);
		`CHK(rd_data, exp)
	endtask
	task automatic refused(input logic exp_en);
		cyc(10);
		`CHK(busy, 1'b0)
		`CHK(wr_en, exp_en)
		`CHK(sdo_oe, 1'b0)
	endtask
	// Bounded so a stuck busy flag ends the run instead of hanging it.
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 4000) begin
			cyc(1);
			n++;
		end
		if (n == 4000) begin
			failures++;
			print_verdict();
		end
	endtask
	function automatic logic [7:0] pat(input int i);
		return 8'(i * 7 + 17);
	endfunction
	// ****
	// Scenarios
	// ****
	task automatic t_no_wel;
		erase(0);
		refused(1'b0);
		send({fss_pkg::OP_SEC_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
		refused(1'b0);
	endtask
	task automatic t_erase;
		wren();
		status(8'h02);
		erase(0);
		`CHK(busy, 1'b1)
		status(8'h03);
		wait_idle();
		`CHK(wr_en, 1'b0)
		status(8'h00);
		rd(10'h000, 8'hff);
		rd(10'h3ff, 8'hff);
	endtask
	task automatic t_program;
		wren();
		q = {fss_pkg::OP_SEC_PROGRAM, 8'h00, 8'h00, 8'hf0};
		for (int i = 0; i < 40; i++) begin
			q.push_back(pat(i));
		end
		send(q, 0);
		`CHK(busy, 1'b1)
		wait_idle();
		`CHK(wr_en, 1'b0)
		rd(10'h0f0, pat(0));
		rd(10'h0ff, pat(15));
		rd(10'h000, pat(16));
		rd(10'h017, pat(39));
		rd(10'h018, 8'hff);
		wren();
		send({fss_pkg::OP_SEC_PROGRAM, 8'h00, 8'h03, 8'h00, 8'h3c}, 0);
		wait_idle();
		rd(10'h300, 8'h3c);
		rd(10'h301, 8'hff);
	endtask
	task automatic t_abort;
		wren();
		erase(3);
		refused(1'b1);
		send({fss_pkg::OP_SEC_PROGRAM, 8'h00, 8'h03, 8'h01, 8'h00}, 5);
		refused(1'b1);
		rd(10'h301, 8'hff);
	endtask
	task automatic t_lock;
		lock = 1'b1;
		cyc(10);
		erase(0);
		refused(1'b1);
		send({fss_pkg::OP_SEC_PROGRAM, 8'h00, 8'h03, 8'h01, 8'h00}, 0);
		refused(1'b1);
		rd(10'h300, 8'h3c);
		status2(8'h04);
		lock = 1'b0;
		cyc(10);
		send({fss_pkg::OP_WR_DISABLE}, 0);
		refused(1'b0);
		erase(0);
		refused(1'b0);
		wren();
	endtask
	task automatic t_quad;
		quad = 1'b1;
		cyc(10);
		erase(0);
		refused(1'b1);
		quad = 1'b0;
		cyc(10);
		erase(0);
		`CHK(busy, 1'b1)
		wait_idle();
		rd(10'h300, 8'hff);
	endtask
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		lock = 1'b0;
		quad = 1'b0;
		rd_addr = 10'h000;
		failures = 0;
		n_tests = 0;
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		cyc(3);
		`CHK(busy, 1'b0)
		`CHK(wr_en, 1'b0)
		t_no_wel();
		t_erase();
		t_program();
		t_abort();
		t_lock();
		t_quad();
		print_verdict();
	end
endmodule
